// >>> shared/charge_limit_params.svh
/*
 * Named constants for the charge current and input voltage limit bank.
 * Assumes it is included by bare name from the package only.
 */
// Notes on behaviour
// - Charge current register sits at offset 01h and resets to 5Eh.
// - Charge register bit 7 enables high-impedance input mode; default off.
// - Charge register bit 6 enables the external limit pin; default on.
// - Charge register bits 5:0 are the charge code, 50 mA per LSB.
// - Charge codes above 2Ch act as 2Ch; below 100 mA act as 100 mA.
// - Input voltage register sits at offset 02h and resets to 84h.
// - With bit 7 set, plug-in detection restores the voltage code default.
// - Input register bit 6 switches on the battery discharge load.
// - Input register bit 5 disables audio avoidance in light load.
// - Input register bits 4:0 give 3.9 V plus 100 mV per LSB.
// - Voltage codes above 10h are applied as 10h, that is 5.5 V.
// - Any host register write enters host mode and restarts the watchdog.
// - Watchdog expiry returns to default mode and restores its fields.
`ifndef CHARGE_LIMIT_PARAMS_SVH
`define CHARGE_LIMIT_PARAMS_SVH
`define TARGET_ADDR 7'h6B
`define CHG_OFFSET 8'h01
`define VIN_OFFSET 8'h02
`define CHG_RESET 8'h5E
`define VIN_RESET 8'h84
`define VIN_WD_KEEP 8'h3F
`define CHG_HIZ_BIT 7
`define CHG_LIM_BIT 6
`define CHG_CODE_HI 5
`define VIN_AUTO_BIT 7
`define VIN_DISCH_BIT 6
`define VIN_AUDIO_BIT 5
`define VIN_CODE_HI 4
`define CHG_CODE_MAX 6'h2C
`define CHG_CODE_MIN 6'h02
`define CHG_CODE_DEF 6'h1E
`define VIN_CODE_MAX 5'h10
`define VIN_CODE_DEF 5'h04
`define BYTE_LAST 3'h7
`define READ_UNMAPPED 8'h00
`endif

// >>> shared/charge_limit_pkg.sv
/*
 * Types for the charge current and input voltage limit bank.
 * Assumes the constants header is on the include path.
 */
`default_nettype none
package charge_limit_pkg;
`include "charge_limit_params.svh"
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_PTR,
		ST_PTR_ACK,
		ST_WDATA,
		ST_WDATA_ACK,
		ST_RDATA,
		ST_RDATA_ACK
	} target_state_t;
endpackage
`default_nettype wire

// >>> logic/two_flop_sync.sv
/*
 * Two flip-flop synchroniser for a group of level inputs.
 * Assumes inputs are asynchronous levels; only stage two is read outside.
 */
`timescale 1ns/100ps
`default_nettype none
module two_flop_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '1
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q;

	// Stage one feeds stage two only, so metastability settles in between.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			meta_q <= INIT;
			sync_o <= INIT;
		end
		else
		begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule // two_flop_sync
`default_nettype wire

// >>> logic/charge_and_input_limit_regs.sv
/*
 * I2C target holding the charge current and input voltage limit registers,
 * with clamped field outputs and default and host mode tracking.
 * Assumes SCL and SDA are open-drain pins resolved outside, that the bus
 * runs slowly against the 40 MHz clock, and that reset command, watchdog
 * expiry and plug-in detection arrive as one-cycle pulses on clk_i.
 */
`timescale 1ns/100ps
`default_nettype none
module charge_and_input_limit_regs
	import charge_limit_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic reg_reset_cmd_i,
	input wire logic watchdog_expired_i,
	input wire logic source_detect_done_i,
	output logic high_impedance_enable_o,
	output logic limit_pin_function_enable_o,
	output logic [5:0] fast_charge_current_code_o,
	output logic input_voltage_limit_autorestore_o,
	output logic battery_discharge_load_enable_o,
	output logic light_load_audio_guard_disable_o,
	output logic [4:0] input_voltage_limit_code_o,
	output logic host_mode_o,
	output logic watchdog_restart_o
);
	import charge_limit_pkg::*;

	logic [1:0] pins_s;
	logic scl_s;
	logic sda_s;
	logic scl_d1_q;
	logic sda_d1_q;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	target_state_t state_q;
	logic [7:0] shift_q;
	logic [7:0] tx_q;
	logic [7:0] ptr_q;
	logic [2:0] cnt_q;
	logic rw_q;
	logic nack_q;
	logic byte_full_q;
	logic wr_en_q;
	logic [7:0] wr_data_q;
	logic [7:0] wr_ptr_q;
	logic [7:0] chg_q;
	logic [7:0] vin_q;
	logic [7:0] rd_data;
	logic [5:0] chg_code;
	logic [4:0] vin_code;

	// Both pins come from outside the clock domain.
	two_flop_sync #(
		.WIDTH(2),
		.INIT(2'h3)
	) u_pin_sync (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.async_i({scl_i, sda_i}),
		.sync_o(pins_s)
	);

	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	// Delayed copies of the synchronised pins for edge detection.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			scl_d1_q <= 1'b1;
			sda_d1_q <= 1'b1;
		end
		else
		begin
			scl_d1_q <= scl_s;
			sda_d1_q <= sda_s;
		end
	end

	// SDA moving while SCL stays high marks start and stop.
	assign scl_rise = scl_s & ~scl_d1_q;
	assign scl_fall = ~scl_s & scl_d1_q;
	assign bus_start = scl_s & scl_d1_q & ~sda_s & sda_d1_q;
	assign bus_stop = scl_s & scl_d1_q & sda_s & ~sda_d1_q;

	// Unmapped offsets read as zero; other registers live elsewhere.
	always_comb
	begin
		rd_data = `READ_UNMAPPED;
		if (ptr_q == `CHG_OFFSET)
			rd_data = chg_q;
		else if (ptr_q == `VIN_OFFSET)
			rd_data = vin_q;
	end

	// Byte-level target sequencer; sampling on SCL rise, driving on fall.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_q <= ST_IDLE;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			ptr_q <= 8'h00;
			cnt_q <= 3'h0;
			rw_q <= 1'b0;
			nack_q <= 1'b0;
			byte_full_q <= 1'b0;
			sda_oe_o <= 1'b0;
			wr_en_q <= 1'b0;
			wr_data_q <= 8'h00;
			wr_ptr_q <= 8'h00;
		end
		else
		begin
			wr_en_q <= 1'b0;
			if (bus_start)
			begin
				state_q <= ST_ADDR;
				cnt_q <= 3'h0;
				byte_full_q <= 1'b0;
				sda_oe_o <= 1'b0;
			end
			else if (bus_stop)
			begin
				state_q <= ST_IDLE;
				sda_oe_o <= 1'b0;
			end
			else
			begin
				case (state_q)
				ST_ADDR, ST_PTR, ST_WDATA:
				begin
					if (scl_rise)
					begin
						shift_q <= {shift_q[6:0], sda_s};
						cnt_q <= cnt_q + 3'h1;
						if (cnt_q == `BYTE_LAST)
							byte_full_q <= 1'b1;
					end
					else if (scl_fall && byte_full_q)
					begin
						// The count reads zero both just after a start and
						// after the eighth bit, so a flag tells them apart.
						byte_full_q <= 1'b0;
						if (state_q == ST_ADDR)
						begin
							if (shift_q[7:1] == `TARGET_ADDR)
							begin
								rw_q <= shift_q[0];
								sda_oe_o <= 1'b1;
								state_q <= ST_ADDR_ACK;
							end
							else
								state_q <= ST_IDLE;
						end
						else if (state_q == ST_PTR)
						begin
							ptr_q <= shift_q;
							sda_oe_o <= 1'b1;
							state_q <= ST_PTR_ACK;
						end
						else
						begin
							wr_en_q <= 1'b1;
							wr_data_q <= shift_q;
							wr_ptr_q <= ptr_q;
							ptr_q <= ptr_q + 8'h01;
							sda_oe_o <= 1'b1;
							state_q <= ST_WDATA_ACK;
						end
					end
				end
				ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK:
				begin
					if (scl_fall)
					begin
						cnt_q <= 3'h0;
						if (state_q == ST_ADDR_ACK && rw_q)
						begin
							tx_q <= rd_data;
							sda_oe_o <= ~rd_data[7];
							state_q <= ST_RDATA;
						end
						else
						begin
							sda_oe_o <= 1'b0;
							state_q <= (state_q == ST_ADDR_ACK) ?
								ST_PTR : ST_WDATA;
						end
					end
				end
				ST_RDATA:
				begin
					if (scl_fall)
					begin
						if (cnt_q == `BYTE_LAST)
						begin
							sda_oe_o <= 1'b0;
							ptr_q <= ptr_q + 8'h01;
							state_q <= ST_RDATA_ACK;
						end
						else
						begin
							tx_q <= {tx_q[6:0], 1'b0};
							sda_oe_o <= ~tx_q[6];
							cnt_q <= cnt_q + 3'h1;
						end
					end
				end
				ST_RDATA_ACK:
				begin
					if (scl_rise)
						nack_q <= sda_s;
					else if (scl_fall)
					begin
						cnt_q <= 3'h0;
						if (nack_q)
							state_q <= ST_IDLE;
						else
						begin
							tx_q <= rd_data;
							sda_oe_o <= ~rd_data[7];
							state_q <= ST_RDATA;
						end
					end
				end
				default:
					state_q <= ST_IDLE;
				endcase
			end
		end
	end

	// The pin is open drain: only ever pulled low.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			sda_o <= 1'b0;
		else
			sda_o <= 1'b0;
	end

	// Charge register: reset command and watchdog both restore all bits.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			chg_q <= `CHG_RESET;
		else if (reg_reset_cmd_i || watchdog_expired_i)
			chg_q <= `CHG_RESET;
		else if (wr_en_q && wr_ptr_q == `CHG_OFFSET)
			chg_q <= wr_data_q;
	end

	// Input register: watchdog spares the audio bit and the voltage code.
	// A host write beats a plug-in restore that lands in the same cycle.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			vin_q <= `VIN_RESET;
		else if (reg_reset_cmd_i)
			vin_q <= `VIN_RESET;
		else if (watchdog_expired_i)
			vin_q <= (vin_q & `VIN_WD_KEEP) |
				(`VIN_RESET & ~`VIN_WD_KEEP);
		else if (wr_en_q && wr_ptr_q == `VIN_OFFSET)
			vin_q <= wr_data_q;
		else if (source_detect_done_i && vin_q[`VIN_AUTO_BIT])
			vin_q[`VIN_CODE_HI:0] <= `VIN_CODE_DEF;
	end

	// Saturation of the applied codes.
	always_comb
	begin
		chg_code = chg_q[`CHG_CODE_HI:0];
		if (chg_code > `CHG_CODE_MAX)
			chg_code = `CHG_CODE_MAX;
		else if (chg_code < `CHG_CODE_MIN)
			chg_code = `CHG_CODE_MIN;
		vin_code = vin_q[`VIN_CODE_HI:0];
		if (vin_code > `VIN_CODE_MAX)
			vin_code = `VIN_CODE_MAX;
	end

	// Field outputs are registered, so they trail the register by a cycle.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			high_impedance_enable_o <= 1'b0;
			limit_pin_function_enable_o <= 1'b1;
			fast_charge_current_code_o <= `CHG_CODE_DEF;
			input_voltage_limit_autorestore_o <= 1'b1;
			battery_discharge_load_enable_o <= 1'b0;
			light_load_audio_guard_disable_o <= 1'b0;
			input_voltage_limit_code_o <= `VIN_CODE_DEF;
		end
		else
		begin
			high_impedance_enable_o <= chg_q[`CHG_HIZ_BIT];
			limit_pin_function_enable_o <= chg_q[`CHG_LIM_BIT];
			fast_charge_current_code_o <= chg_code;
			input_voltage_limit_autorestore_o <= vin_q[`VIN_AUTO_BIT];
			battery_discharge_load_enable_o <= vin_q[`VIN_DISCH_BIT];
			light_load_audio_guard_disable_o <= vin_q[`VIN_AUDIO_BIT];
			input_voltage_limit_code_o <= vin_code;
		end
	end

	// Mode tracking; expiry wins over a write in the same cycle.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			host_mode_o <= 1'b0;
			watchdog_restart_o <= 1'b0;
		end
		else
		begin
			watchdog_restart_o <= wr_en_q;
			if (watchdog_expired_i)
				host_mode_o <= 1'b0;
			else if (wr_en_q)
				host_mode_o <= 1'b1;
		end
	end
endmodule // charge_and_input_limit_regs
`default_nettype wire

// >>> verif/limit_regs_assertions.sv
/* Checker for the limit register bank field outputs.
 Assumes event inputs are one-cycle pulses on clk_i. */
`timescale 1ns/100ps
`default_nettype none
module limit_regs_assertions (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic reg_reset_cmd_i,
	input wire logic watchdog_expired_i,
	input wire logic source_detect_done_i,
	input wire logic high_impedance_enable_o,
	input wire logic limit_pin_function_enable_o,
	input wire logic [5:0] fast_charge_current_code_o,
	input wire logic input_voltage_limit_autorestore_o,
	input wire logic battery_discharge_load_enable_o,
	input wire logic light_load_audio_guard_disable_o,
	input wire logic [4:0] input_voltage_limit_code_o,
	input wire logic host_mode_o,
	input wire logic watchdog_restart_o
);
	logic [7:0] chg;
	logic [7:0] vin;
	logic wd;
	// Fields regrouped as register images to keep the checks short.
	assign chg = {high_impedance_enable_o, limit_pin_function_enable_o,
		fast_charge_current_code_o};
	assign vin = {input_voltage_limit_autorestore_o,
		battery_discharge_load_enable_o, light_load_audio_guard_disable_o,
		input_voltage_limit_code_o};
	assign wd = watchdog_expired_i && !reg_reset_cmd_i;
	// One clock domain, so one default clock and disable.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	chk_chg_ceiling: assert property (chg[5:0] <= 6'h2C)
		else $error("charge code above ceiling");
	chk_chg_floor: assert property (chg[5:0] >= 6'h02)
		else $error("charge code below floor");
	chk_vin_ceiling: assert property (vin[4:0] <= 5'h10)
		else $error("voltage code above ceiling");
	chk_cmd_defaults: assert property (reg_reset_cmd_i |-> ##2
		(chg == 8'h5E && vin == 8'h84)) else $error("reset command missed");
	chk_wd_defaults: assert property (wd |-> ##2
		(chg == 8'h5E && vin[7:6] == 2'b10)) else $error("expiry missed");
	chk_wd_keep: assert property (wd && !source_detect_done_i |-> ##2
		$stable(vin[5:0])) else $error("expiry lost kept fields");
	chk_wd_mode: assert property (watchdog_expired_i |=> !host_mode_o)
		else $error("host mode kept after expiry");
	chk_write_mode: assert property (watchdog_restart_o &&
		!$past(watchdog_expired_i) |-> host_mode_o) else $error("no host mode");
	chk_restart_pulse: assert property (watchdog_restart_o |=>
		!watchdog_restart_o) else $error("restart longer than a cycle");
	chk_plugin_restore: assert property (source_detect_done_i && vin[7] &&
		!reg_reset_cmd_i && !watchdog_expired_i |-> ##2 vin[4:0] == 5'h04)
		else $error("plug-in restore missed");
	cover property (reg_reset_cmd_i);
	cover property (watchdog_expired_i && host_mode_o);
	cover property (source_detect_done_i && vin[7]);
endmodule // limit_regs_assertions
bind charge_and_input_limit_regs limit_regs_assertions chk (.clk_i,
	.rst_b_i, .reg_reset_cmd_i, .watchdog_expired_i, .source_detect_done_i,
	.high_impedance_enable_o, .limit_pin_function_enable_o,
	.fast_charge_current_code_o, .input_voltage_limit_autorestore_o,
	.battery_discharge_load_enable_o, .light_load_audio_guard_disable_o,
	.input_voltage_limit_code_o, .host_mode_o, .watchdog_restart_o);
`default_nettype wire

// >>> verif/i2c_host_model.sv
/* Host controller model on the two-wire bus.
 Assumes a pull-up outside resolves SDA; SCL is driven push-pull. */
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_pull_o
);
	// Idle with SDA released; the pull-up then holds it high.
	initial
	begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end
	// Ten clocks a step keeps phases above the 8-clock minimum.
	task automatic hp();
		repeat (10) @(posedge clk_i);
		#2;
	endtask
	// Also serves as repeated start; SDA is released while SCL is low, then pulled low while SCL is high.
	task automatic start();
		hp();
		sda_pull_o = 1'b0;
		hp();
		scl_o = 1'b1;
		hp();
		sda_pull_o = 1'b1;
		hp();
		scl_o = 1'b0;
	endtask
	task automatic stop();
		hp();
		sda_pull_o = 1'b1;
		hp();
		scl_o = 1'b1;
		hp();
		sda_pull_o = 1'b0;
		hp();
	endtask
	// Eight bits then the acknowledge slot; a one releases SDA.
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--)
		begin
			hp();
			sda_pull_o = !d[i];
			hp();
			scl_o = 1'b1;
			hp();
			q[i] = sda_i;
			scl_o = 1'b0;
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] p,
		input logic [7:0] d, output logic nak);
		logic [8:0] q1, q2, q3;
		start();
		xfer({a, 2'b01}, q1);
		xfer({p, 1'b1}, q2);
		xfer({d, 1'b1}, q3);
		stop();
		nak = q1[0] | q2[0] | q3[0];
	endtask
	// The final byte is refused by the host to end the read.
	task automatic rd(input logic [7:0] p, output logic [7:0] v);
		logic [8:0] q;
		start();
		xfer({7'h6B, 2'b01}, q);
		xfer({p, 1'b1}, q);
		start();
		xfer({7'h6B, 2'b11}, q);
		xfer(9'h1FF, q);
		stop();
		v = q[8:1];
	endtask
endmodule // i2c_host_model
`default_nettype wire

// >>> verif/tb.sv
/* Self-checking bench for the limit register bank.
 Assumes the host model and the checker are compiled with it. */
`timescale 1ns/100ps
`default_nettype none
module tb;
	import charge_limit_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [2:0] ev = 3'h0;
	logic scl, pull, oe, high_impedance_input_mode, lim, aut, dis, aud, host, rs, nak;
	logic [5:0] code;
	logic [4:0] vc;
	logic [7:0] v;
	logic [16:0] f;
	logic [7:0] cw [4] = '{8'h40, 8'h41, 8'h2D, 8'h03};
	logic [7:0] ce [4] = '{8'h42, 8'h42, 8'h2C, 8'h03};
	int mismatches = 0;
	int tests_run = 0;
	int cyc = 0;
	int restarts = 0;
	wire sda;
	// Open-drain data line with a pull-up.
	assign sda = !(pull | oe);
	assign f = {high_impedance_input_mode, lim, code, aut, dis, aud, vc, host};
	always #12.5 clk = ~clk;
	charge_and_input_limit_regs dut (.clk_i(clk), .rst_b_i(rst_b),
		.scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(oe),
		.reg_reset_cmd_i(ev[0]), .watchdog_expired_i(ev[1]),
		.source_detect_done_i(ev[2]), .high_impedance_enable_o(high_impedance_input_mode),
		.limit_pin_function_enable_o(lim), .fast_charge_current_code_o(code),
		.input_voltage_limit_autorestore_o(aut),
		.battery_discharge_load_enable_o(dis),
		.light_load_audio_guard_disable_o(aud),
		.input_voltage_limit_code_o(vc), .host_mode_o(host),
		.watchdog_restart_o(rs));
	i2c_host_model host_m (.clk_i(clk), .sda_i(sda), .scl_o(scl),
		.sda_pull_o(pull));
	task automatic check(input string n, input logic [16:0] s,
		input logic [16:0] e);
		tests_run++;
		if (s !== e)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic fl(input logic [16:0] e);
		check("fields", f, e);
	endtask
	task automatic rdc(input logic [7:0] p, input logic [7:0] e);
		host_m.rd(p, v);
		check("readback", {9'h0, v}, {9'h0, e});
	endtask
	task automatic wrc(input logic [6:0] a, input logic [7:0] p,
		input logic [7:0] d, input logic e);
		host_m.wr(a, p, d, nak);
		check("ack", {16'h0, nak}, {16'h0, e});
	endtask
	// Event pulses last one cycle; fields settle two cycles later.
	task automatic pulse(input int i);
		@(posedge clk);
		#2 ev[i] = 1'b1;
		@(posedge clk);
		#2 ev[i] = 1'b0;
		repeat (3) @(posedge clk);
		#2;
	endtask
	// Restart pulses are counted so that every accepted write data byte is seen.
	always @(posedge clk)
	begin
		if (rs === 1'b1)
			restarts++;
	end
	// A hang is cut short well past the expected run length.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			mismatches++;
			tally_and_finish();
		end
	end
	// Main sequence of bus accesses and events.
	initial
	begin
		repeat (3) @(posedge clk);
		#2 rst_b = 1'b1;
		repeat (4) @(posedge clk);
		#2;
		fl({8'h5E, 8'h84, 1'b0});
		rdc(8'h01, 8'h5E);
		rdc(8'h02, 8'h84);
		wrc(7'h6B, 8'h01, 8'hBF, 1'b0);
		fl({8'hAC, 8'h84, 1'b1});
		check("restarts", 17'(restarts), 17'd1);
		rdc(8'h01, 8'hBF);
		for (int i = 0; i < 4; i++)
		begin
			wrc(7'h6B, 8'h01, cw[i], 1'b0);
			fl({ce[i], 8'h84, 1'b1});
		end
		wrc(7'h6B, 8'h02, 8'h7F, 1'b0);
		fl({8'h03, 8'h70, 1'b1});
		wrc(7'h6B, 8'h02, 8'h6F, 1'b0);
		pulse(2);
		fl({8'h03, 8'h6F, 1'b1});
		wrc(7'h6B, 8'h02, 8'hAF, 1'b0);
		pulse(2);
		fl({8'h03, 8'hA4, 1'b1});
		wrc(7'h6B, 8'h02, 8'hEF, 1'b0);
		wrc(7'h6B, 8'h01, 8'h81, 1'b0);
		fl({8'h82, 8'hEF, 1'b1});
		pulse(1);
		fl({8'h5E, 8'hAF, 1'b0});
		rdc(8'h02, 8'hAF);
		wrc(7'h6A, 8'h01, 8'h00, 1'b1);
		fl({8'h5E, 8'hAF, 1'b0});
		check("restarts", 17'(restarts), 17'd10);
		wrc(7'h6B, 8'h03, 8'hFF, 1'b0);
		check("restarts", 17'(restarts), 17'd11);
		fl({8'h5E, 8'hAF, 1'b1});
		rdc(8'h03, 8'h00);
		pulse(0);
		fl({8'h5E, 8'h84, 1'b1});
		tally_and_finish();
	end
endmodule // tb
`default_nettype wire
